// file: sarseq_defines.vh
// Constants for the successive-approximation converter sequencer.
// Assumes it is included once per design file by its bare name.
`ifndef SARSEQ_DEFINES_VH
`define SARSEQ_DEFINES_VH

// Register word addresses (one aligned word each)
`define SARSEQ_ADDR_CTRL0      4'h0
`define SARSEQ_ADDR_CTRL1      4'h1
`define SARSEQ_ADDR_CTRL2      4'h2
`define SARSEQ_ADDR_RES_LOW    4'h3
`define SARSEQ_ADDR_RES_HIGH   4'h4
`define SARSEQ_ADDR_IRQ_FLAGS  4'h5
`define SARSEQ_ADDR_IRQ_EN     4'h6
`define SARSEQ_ADDR_ANSEL      4'h7
`define SARSEQ_ADDR_PINDIR     4'h8
`define SARSEQ_ADDR_PORT       4'h9

// Field positions in control 0
`define SARSEQ_C0_ENABLE       0
`define SARSEQ_C0_GO           1
`define SARSEQ_C0_CHS_LSB      2
// Field positions in control 2
`define SARSEQ_C2_CLK_LSB      0
`define SARSEQ_C2_ACQ_LSB      3
`define SARSEQ_C2_JUSTIFY      7
// Flag position in the irq flag and enable words
`define SARSEQ_IRQ_DONE        6

// Reset values
`define SARSEQ_RST_CTRL0       8'h00
`define SARSEQ_RST_CTRL1       8'h00
`define SARSEQ_RST_CTRL2       8'h00
`define SARSEQ_RST_PINS        12'hFFF

// Timing counts: conversion length in conversion-clock periods, arm delay and oscillator divider in clk cycles
`define SARSEQ_CONV_PERIODS    4'hB
`define SARSEQ_ARM_CYCLES      3'h4
`define SARSEQ_OSC_DIV         5'h11

`endif

// file: sarseq_top.v
// Sequencer, register slave and result formatting of a 10-bit SAR converter.
// Assumes an Avalon-MM master on clk and an analog comparator outside that
// answers cmp_high for the trial code on dac_code within one clock.
`include "sarseq_defines.vh"

module sarseq_top (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire [11:0] pin_level,
  input  wire        cmp_high,
  output reg  [9:0]  dac_code,
  output reg  [3:0]  mux_channel,
  output reg  [1:0]  pos_ref_select,
  output reg  [1:0]  neg_ref_select,
  output reg         sample_on,
  output reg         conv_done_irq,
  output reg         wake_request
);

  //--------------------------------------------------------------------------
  // State
  //--------------------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_ARM  = 2'h1;
  localparam ST_ACQ  = 2'h2;
  localparam ST_CONV = 2'h3;

  reg [7:0]  converter_control_0;
  reg [7:0]  converter_control_1;
  reg [7:0]  converter_control_2;
  reg [7:0]  result_low_reg;
  reg [7:0]  result_high_reg;
  reg        conv_done_flag;
  reg        conv_done_irq_en;
  reg [11:0] analog_select_bit;
  reg [11:0] pin_direction_bit;
  reg [1:0]  state_reg;
  reg [5:0]  div_reg;
  reg        tad_tick;
  reg [4:0]  acq_cnt_reg;
  reg [3:0]  bit_cnt_reg;
  reg [2:0]  arm_cnt_reg;
  reg [9:0]  sar_reg;
  reg        ack_pending;
  wire       conv_enter;

  wire       converter_enable = converter_control_0[`SARSEQ_C0_ENABLE];
  wire       go_busy          = converter_control_0[`SARSEQ_C0_GO];
  wire [2:0] conv_clock_select     = converter_control_2[`SARSEQ_C2_CLK_LSB +: 3];
  wire [2:0] acquisition_delay_sel = converter_control_2[`SARSEQ_C2_ACQ_LSB +: 3];
  wire       result_justify_sel    = converter_control_2[`SARSEQ_C2_JUSTIFY];

  wire       bus_hit = (avs_read | avs_write) & ~ack_pending;
  wire       wr_en   = avs_write & bus_hit & avs_byteenable[0];
  wire [7:0] wdat    = avs_writedata[7:0];

  //--------------------------------------------------------------------------
  // Conversion clock
  //--------------------------------------------------------------------------
  reg [5:0] div_limit;
  always @* begin
    case (conv_clock_select)
      3'h0:    div_limit = 6'h01;
      3'h4:    div_limit = 6'h03;
      3'h1:    div_limit = 6'h07;
      3'h5:    div_limit = 6'h0F;
      3'h2:    div_limit = 6'h1F;
      3'h6:    div_limit = 6'h3F;
      default: div_limit = `SARSEQ_OSC_DIV - 6'h01;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b || state_reg == ST_IDLE) begin
      div_reg  <= 6'h00;
      tad_tick <= 1'b0;
    end else if (conv_enter) begin
      // Restart the period so the first trial code settles before its tick
      div_reg  <= 6'h00;
      tad_tick <= 1'b0;
    end else if (div_reg >= div_limit) begin
      div_reg  <= 6'h00;
      tad_tick <= 1'b1;
    end else begin
      div_reg  <= div_reg + 6'h01;
      tad_tick <= 1'b0;
    end
  end

  reg [4:0] acq_len;
  always @* begin
    case (acquisition_delay_sel)
      3'h1:    acq_len = 5'h02;
      3'h2:    acq_len = 5'h04;
      3'h3:    acq_len = 5'h06;
      3'h4:    acq_len = 5'h08;
      3'h5:    acq_len = 5'h0C;
      3'h6:    acq_len = 5'h10;
      3'h7:    acq_len = 5'h14;
      default: acq_len = 5'h00;
    endcase
  end

  assign conv_enter = (state_reg == ST_ARM && arm_cnt_reg == `SARSEQ_ARM_CYCLES - 3'h1) ||
                      (state_reg == ST_ACQ && tad_tick && acq_cnt_reg == acq_len - 5'h01);

  //--------------------------------------------------------------------------
  // Sequencer decode
  //--------------------------------------------------------------------------
  wire [9:0] trial     = sar_reg | (10'h200 >> bit_cnt_reg);
  wire       conv_last = tad_tick && bit_cnt_reg == `SARSEQ_CONV_PERIODS - 4'h1;
  wire       go_set    = wr_en && avs_address == `SARSEQ_ADDR_CTRL0 &&
                         wdat[`SARSEQ_C0_GO] && !go_busy && converter_enable;
  wire       done_evt  = state_reg == ST_CONV && conv_last;
  wire [9:0] result    = sar_reg;
  wire       wr_ctrl0  = wr_en && avs_address == `SARSEQ_ADDR_CTRL0;
  wire       wr_ctrl1  = wr_en && avs_address == `SARSEQ_ADDR_CTRL1;
  wire       wr_ctrl2  = wr_en && avs_address == `SARSEQ_ADDR_CTRL2;
  wire       wr_flags  = wr_en && avs_address == `SARSEQ_ADDR_IRQ_FLAGS;
  wire       wr_irq_en = wr_en && avs_address == `SARSEQ_ADDR_IRQ_EN;
  wire       wr_ansel  = wr_en && avs_address == `SARSEQ_ADDR_ANSEL;
  wire       wr_pindir = wr_en && avs_address == `SARSEQ_ADDR_PINDIR;

  //--------------------------------------------------------------------------
  // Sequencer next state
  //--------------------------------------------------------------------------
  reg [1:0] state_next;
  reg [4:0] acq_cnt_next;
  reg [3:0] bit_cnt_next;
  reg [2:0] arm_cnt_next;
  reg [9:0] sar_next;

  always @* begin
    state_next   = state_reg;
    acq_cnt_next = acq_cnt_reg;
    bit_cnt_next = bit_cnt_reg;
    arm_cnt_next = arm_cnt_reg;
    sar_next     = sar_reg;
    case (state_reg)
      ST_IDLE: begin
        if (go_set) begin
          sar_next     = 10'h000;
          bit_cnt_next = 4'h0;
          acq_cnt_next = 5'h00;
          arm_cnt_next = 3'h0;
          state_next   = (acq_len == 5'h00) ? ST_ARM : ST_ACQ;
        end
      end
      ST_ARM: begin
        arm_cnt_next = arm_cnt_reg + 3'h1;
        if (arm_cnt_reg == `SARSEQ_ARM_CYCLES - 3'h1)
          state_next = ST_CONV;
      end
      ST_ACQ: begin
        if (tad_tick) begin
          acq_cnt_next = acq_cnt_reg + 5'h01;
          if (acq_cnt_reg == acq_len - 5'h01)
            state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (tad_tick) begin
          bit_cnt_next = bit_cnt_reg + 4'h1;
          if (bit_cnt_reg < 4'hA && cmp_high)
            sar_next = trial;
        end
        if (conv_last)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
    if (!converter_enable)
      state_next = ST_IDLE;
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      state_reg   <= ST_IDLE;
      acq_cnt_reg <= 5'h00;
      bit_cnt_reg <= 4'h0;
      arm_cnt_reg <= 3'h0;
      sar_reg     <= 10'h000;
    end else begin
      state_reg   <= state_next;
      acq_cnt_reg <= acq_cnt_next;
      bit_cnt_reg <= bit_cnt_next;
      arm_cnt_reg <= arm_cnt_next;
      sar_reg     <= sar_next;
    end
  end

  //--------------------------------------------------------------------------
  // Control registers
  //--------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      converter_control_0 <= `SARSEQ_RST_CTRL0;
    end else begin
      if (wr_ctrl0)
        converter_control_0 <= {2'h0, wdat[5:2], go_set, wdat[0]};
      if (done_evt)
        converter_control_0[`SARSEQ_C0_GO] <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (!rst_b)
      converter_control_1 <= `SARSEQ_RST_CTRL1;
    else if (wr_ctrl1)
      converter_control_1 <= {4'h0, wdat[3:0]};
  end

  always @(posedge clk) begin
    if (!rst_b)
      converter_control_2 <= `SARSEQ_RST_CTRL2;
    else if (wr_ctrl2)
      converter_control_2 <= wdat;
  end

  always @(posedge clk) begin
    if (!rst_b)
      conv_done_irq_en <= 1'b0;
    else if (wr_irq_en)
      conv_done_irq_en <= wdat[`SARSEQ_IRQ_DONE];
  end

  always @(posedge clk) begin
    if (!rst_b)
      analog_select_bit <= `SARSEQ_RST_PINS;
    else if (wr_ansel)
      analog_select_bit <= avs_writedata[11:0];
  end

  always @(posedge clk) begin
    if (!rst_b)
      pin_direction_bit <= `SARSEQ_RST_PINS;
    else if (wr_pindir)
      pin_direction_bit <= avs_writedata[11:0];
  end

  // Set wins over a software clear in the same cycle
  always @(posedge clk) begin
    if (!rst_b)
      conv_done_flag <= 1'b0;
    else if (done_evt)
      conv_done_flag <= 1'b1;
    else if (wr_flags)
      conv_done_flag <= wdat[`SARSEQ_IRQ_DONE];
  end

  //--------------------------------------------------------------------------
  // Result formatting
  //--------------------------------------------------------------------------
  reg [7:0] result_low_next;
  reg [7:0] result_high_next;

  always @* begin
    if (result_justify_sel) begin
      result_high_next = {6'h00, result[9:8]};
      result_low_next  = result[7:0];
    end else begin
      result_high_next = result[9:2];
      result_low_next  = {result[1:0], 6'h00};
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      result_low_reg  <= 8'h00;
      result_high_reg <= 8'h00;
    end else if (done_evt) begin
      result_low_reg  <= result_low_next;
      result_high_reg <= result_high_next;
    end
  end

  //--------------------------------------------------------------------------
  // Register read
  //--------------------------------------------------------------------------
  reg [31:0] rdata;
  always @* begin
    case (avs_address)
      `SARSEQ_ADDR_CTRL0:     rdata = {24'h0, converter_control_0};
      `SARSEQ_ADDR_CTRL1:     rdata = {24'h0, converter_control_1};
      `SARSEQ_ADDR_CTRL2:     rdata = {24'h0, converter_control_2};
      `SARSEQ_ADDR_RES_LOW:   rdata = {24'h0, result_low_reg};
      `SARSEQ_ADDR_RES_HIGH:  rdata = {24'h0, result_high_reg};
      `SARSEQ_ADDR_IRQ_FLAGS: rdata = {25'h0, conv_done_flag, 6'h00};
      `SARSEQ_ADDR_IRQ_EN:    rdata = {25'h0, conv_done_irq_en, 6'h00};
      `SARSEQ_ADDR_ANSEL:     rdata = {20'h0, analog_select_bit};
      `SARSEQ_ADDR_PINDIR:    rdata = {20'h0, pin_direction_bit};
      `SARSEQ_ADDR_PORT:      rdata = {20'h0, pin_level & ~analog_select_bit};
      default:                rdata = 32'h0;
    endcase
  end

  //--------------------------------------------------------------------------
  // Bus handshake
  //--------------------------------------------------------------------------
  // One wait state per access; the cycle that shows an acknowledge is never taken
  always @(posedge clk) begin
    if (!rst_b) begin
      avs_readdata    <= 32'h0;
      avs_waitrequest <= 1'b1;
      ack_pending     <= 1'b0;
    end else begin
      ack_pending     <= bus_hit;
      avs_waitrequest <= ~bus_hit;
      if (bus_hit && avs_read)
        avs_readdata <= rdata;
    end
  end

  //--------------------------------------------------------------------------
  // Analog front-end controls and interrupt
  //--------------------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      dac_code       <= 10'h000;
      mux_channel    <= 4'h0;
      pos_ref_select <= 2'h0;
      neg_ref_select <= 2'h0;
      sample_on      <= 1'b0;
    end else begin
      dac_code       <= (state_reg == ST_CONV) ? trial : 10'h000;
      mux_channel    <= converter_control_0[`SARSEQ_C0_CHS_LSB +: 4];
      pos_ref_select <= converter_control_1[3:2];
      neg_ref_select <= converter_control_1[1:0];
      sample_on      <= converter_enable && state_reg != ST_CONV;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      conv_done_irq <= 1'b0;
      wake_request  <= 1'b0;
    end else begin
      conv_done_irq <= conv_done_flag & conv_done_irq_en;
      wake_request  <= conv_done_flag & conv_done_irq_en;
    end
  end

endmodule // sarseq_top

// file: sarseq_checker.sv
// Port-level checks on the converter sequencer.
// Assumes one clock domain with a synchronous active-low reset.
module sarseq_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic [9:0]  dac_code,
  input wire logic [3:0]  mux_channel,
  input wire logic [1:0]  pos_ref_select,
  input wire logic [1:0]  neg_ref_select,
  input wire logic        sample_on,
  input wire logic        conv_done_irq,
  input wire logic        wake_request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire go_acc = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_writedata[1:0] == 2'h3;
  property p_ack_one; $fell(avs_waitrequest) |=> avs_waitrequest; endproperty
  a_ack_one: assert property (p_ack_one) else $error("Waitrequest low too long");
  property p_ack_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("Acknowledge without request");
  property p_wake; wake_request == conv_done_irq; endproperty
  a_wake: assert property (p_wake) else $error("Wake differs from irq");
  property p_irq_clr; $fell(conv_done_irq) |-> $past(avs_write) || $past(avs_write, 2); endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("Irq fell without write");
  property p_mux; $changed(mux_channel) |-> $past(avs_write) || $past(avs_write, 2); endproperty
  a_mux: assert property (p_mux) else $error("Channel moved without write");
  property p_refs;
    $changed({pos_ref_select, neg_ref_select}) |-> $past(avs_write) || $past(avs_write, 2);
  endproperty
  a_refs: assert property (p_refs) else $error("Reference moved without write");
  property p_idle_dac; sample_on && $past(sample_on) |-> dac_code == 10'h000; endproperty
  a_idle_dac: assert property (p_idle_dac) else $error("Trial code while sampling");
  property p_first; $rose(dac_code != 10'h000) |-> dac_code == 10'h200; endproperty
  a_first: assert property (p_first) else $error("First trial code wrong");
  c_go: cover property (go_acc && avs_byteenable[0]);
  c_irq: cover property ($rose(conv_done_irq));
  c_conv: cover property ($rose(dac_code != 10'h000));
endmodule // sarseq_checker

bind sarseq_top sarseq_checker chk_i (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .dac_code(dac_code),
  .mux_channel(mux_channel), .pos_ref_select(pos_ref_select), .neg_ref_select(neg_ref_select),
  .sample_on(sample_on), .conv_done_irq(conv_done_irq), .wake_request(wake_request));

// file: sarseq_cmp_model.sv
// Comparator and input multiplexer seen by the sequencer.
// Assumes the bench sets the analog level; each channel XORs its number into it.
module sarseq_cmp_model (
  input wire logic [9:0] dac_code,
  input wire logic [3:0] mux_channel,
  input wire logic [9:0] vin_base,
  output logic           cmp_high
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] vin;
  assign vin = vin_base ^ {6'h00, mux_channel};
  assign cmp_high = (vin >= dac_code);
endmodule // sarseq_cmp_model

// file: tb.sv
// Self-checking bench for the converter sequencer.
// Assumes the comparator model and the bound port checker.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, rst_b = 0, avs_read = 0, avs_write = 0;
  logic [3:0]  avs_address = 0, avs_byteenable = 0, mux_channel;
  logic [31:0] avs_writedata = 0, avs_readdata, q, r;
  logic        avs_waitrequest, cmp_high, sample_on, conv_done_irq, wake_request;
  logic [11:0] pin_level = 0;
  logic [9:0]  dac_code, vin_base = 0;
  logic [1:0]  pos_ref_select, neg_ref_select;
  integer      seed = 32'h027c87d1, bad_count = 0, n_tests = 0, a_len, c_len, a1, c0, i;
  integer      dv[8] = '{2, 8, 32, 17, 4, 16, 64, 17};
  integer      aq[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  always #50 clk = ~clk;
  sarseq_top dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_level(pin_level),
    .cmp_high(cmp_high), .dac_code(dac_code), .mux_channel(mux_channel),
    .pos_ref_select(pos_ref_select), .neg_ref_select(neg_ref_select), .sample_on(sample_on),
    .conv_done_irq(conv_done_irq), .wake_request(wake_request));
  sarseq_cmp_model cmp (.dac_code(dac_code), .mux_channel(mux_channel), .vin_base(vin_base),
    .cmp_high(cmp_high));
  // ----------------------------------------
  // Bus and comparison helpers
  // ----------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [3:0] be, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) bad_count++;
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bus(1, a, 4'hF, d);
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    bus(0, a, 4'hF, 0);
    chk(q, e);
  endtask
  // One conversion, timing its acquisition and conversion spans
  task conv(input logic [7:0] c2, input logic [3:0] ch);
    logic [9:0] v;
    wr(2, c2);
    v = vin_base ^ {6'h00, ch};
    wr(0, {ch, 2'h1});
    wr(0, {ch, 2'h3});
    a_len = 0;
    c_len = 0;
    while (sample_on !== 1'b0 && a_len < 3000) begin
      @(posedge clk);
      a_len++;
    end
    while (sample_on !== 1'b1 && c_len < 3000) begin
      @(posedge clk);
      c_len++;
    end
    rd(0, {ch, 2'h1});
    rd(5, 32'h40);
    rd(3, c2[7] ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h00});
    rd(4, c2[7] ? {22'h0, v[9:8]} : {24'h0, v[9:2]});
    chk(conv_done_irq, 0);
    wr(6, 32'h40);
    repeat (2) @(posedge clk);
    chk({conv_done_irq, wake_request}, 2'h3);
    wr(5, 0);
    wr(6, 0);
    repeat (2) @(posedge clk);
    chk(conv_done_irq, 0);
    rd(5, 0);
  endtask
  task end_sim;
    $display("Counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1;
    for (i = 0; i < 11; i++) rd(i, (i == 7 || i == 8) ? 32'hFFF : 32'h0);
    wr(10, 32'hFF);
    rd(10, 0);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      pin_level <= $random(seed);
      r = $random(seed);
      wr(7, r);
      wr(8, $random(seed));
      rd(9, pin_level & ~r[11:0]);
    end
    bus(1, 7, 4'h0, 0);
    rd(7, r[11:0]);
    $display("test port done");
    for (i = 0; i < 16; i++) begin
      wr(1, i);
      @(posedge clk);
      chk({pos_ref_select, neg_ref_select}, i);
      rd(1, i);
    end
    $display("test refs done");
    for (i = 0; i < 16; i++) begin
      wr(0, {i[3:0], 2'h1});
      @(posedge clk);
      chk(mux_channel, i);
    end
    wr(0, 32'h2);
    repeat (40) @(posedge clk);
    chk(sample_on, 0);
    rd(5, 0);
    $display("test channel done");
    vin_base = $random(seed);
    for (i = 0; i < 8; i++) begin
      conv({5'h11, i[2:0]}, 4'h3);
      if (i == 0) c0 = c_len;
      chk(c_len - c0, 11 * (dv[i] - 2));
    end
    $display("test clock done");
    conv(8'h00, 4'h9);
    chk(a_len, 5);
    for (i = 1; i < 8; i++) begin
      conv({2'h0, i[2:0], 3'h0}, 4'h9);
      if (i == 1) a1 = a_len;
      chk(a_len - a1, 2 * (aq[i] - 2));
    end
    $display("test acquisition done");
    for (i = 0; i < 6; i++) begin
      vin_base = $random(seed);
      r = $random(seed);
      conv({r[7], 1'b0, r[5:0]}, r[11:8]);
    end
    $display("test random done");
    end_sim;
  end
endmodule // tb
